// *** logic/tac_step_control.sv ***
// tracking converter step control: start, reload, up/down stepping, stop
`timescale 1ns/1ps
`include "tac_params.svh"
module tac_step_control #(
    parameter int                 STEP_DIV  = `TAC_STEP_DIV,
    parameter logic [`TAC_POS_W-1:0] RELOAD_POS = `TAC_RELOAD_POS
) (
    input  wire logic                  clk,
    input  wire logic                  nrst,
    input  wire logic                  start,
    input  wire logic                  auto_reload,
    input  wire logic                  level_comparator,
    output logic                       step_pulse,
    output logic                       step_up,
    output logic [`TAC_POS_W-1:0]      position,
    output logic                       busy,
    output logic                       done,
    output tac_pkg::tac_status_t       status
);
    logic                  rst_meta_ff;
    logic                  rst_sync_ff;
    tac_pkg::tac_state_t   state_ff;
    tac_pkg::tac_state_t   nxt_state;
    logic                  start_d_ff;
    logic                  cmp_d_ff;
    logic [1:0]            rise_cnt_ff;
    logic [9:0]            step_cnt_ff;
    logic [`TAC_POS_W-1:0] pos_ff;
    logic                  tick;
    logic                  start_rise;
    logic                  cmp_rise;
    logic                  stop_on_rise;
    logic                  stop_on_guard;
    logic                  stop_now;
    logic                  stepping;
    logic                  step_now;
    logic                  will_be_busy;

    function automatic logic [`TAC_POS_W-1:0] sat_step(
        input logic [`TAC_POS_W-1:0] p,
        input logic                  up
    );
        if (up)
            sat_step = (p == `TAC_POS_MAX) ? p : p + 10'h001;
        else
            sat_step = (p == `TAC_POS_MIN) ? p : p - 10'h001;
    endfunction

    // true while the wiper is being moved; shared by counters, position and outputs
    function automatic logic is_stepping(
        input tac_pkg::tac_state_t s
    );
        is_stepping = (s == tac_pkg::TAC_STEP);
    endfunction

    // idle is the only state in which no conversion is in progress
    function automatic logic is_active(
        input tac_pkg::tac_state_t s
    );
        is_active = (s != tac_pkg::TAC_IDLE);
    endfunction

    // every flop behind rst_sync_ff leaves reset on the same edge, whatever the phase of nrst
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end
        else
        begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    // the divider only runs while stepping, so the first step is a full period late
    tac_step_tick #(
        .DIV (STEP_DIV)
    ) u_tick (
        .clk   (clk),
        .rst_n (rst_sync_ff),
        .run   (stepping),
        .tick  (tick)
    );

    assign stepping      = is_stepping(state_ff);
    assign will_be_busy  = is_active(nxt_state);
    assign start_rise    = start && !start_d_ff;
    // a comparator rise is seen in the cycle it happens, against the previous level held in cmp_d_ff
    assign cmp_rise      = level_comparator && !cmp_d_ff;
    // the third rise ends the conversion: two are already counted when it arrives
    assign stop_on_rise  = cmp_rise && (rise_cnt_ff == `TAC_STOP_EDGES - 2'h1);
    // the step guard is a backstop; the analog loop should stop far sooner,
    // but a stuck or saturated input would otherwise step forever
    assign stop_on_guard = (step_cnt_ff == 10'(`TAC_MAX_STEPS));
    assign stop_now      = stop_on_rise || stop_on_guard;
    // no step is taken in the cycle that stops, so the final position stands
    assign step_now      = stepping && tick && !stop_now;

    // both delay flops reset low, the idle level of start and of a low comparator
    always_ff @(posedge clk or negedge rst_sync_ff)
    begin
        if (!rst_sync_ff)
        begin
            start_d_ff <= 1'b0;
            cmp_d_ff   <= 1'b0;
        end
        else
        begin
            start_d_ff <= start;
            cmp_d_ff   <= level_comparator;
        end
    end

    // only idle looks at start, so start edges during a conversion are ignored
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            tac_pkg::TAC_IDLE:
                if (start_rise)
                    nxt_state = auto_reload ? tac_pkg::TAC_LOAD : tac_pkg::TAC_STEP;
            tac_pkg::TAC_LOAD:
                nxt_state = tac_pkg::TAC_STEP;
            tac_pkg::TAC_STEP:
                if (stop_now)
                    nxt_state = tac_pkg::TAC_IDLE;
            default:
                nxt_state = tac_pkg::TAC_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_sync_ff)
    begin
        if (!rst_sync_ff)
            state_ff <= tac_pkg::TAC_IDLE;
        else
            state_ff <= nxt_state;
    end

    // rising edges and steps are counted per conversion
    always_ff @(posedge clk or negedge rst_sync_ff)
    begin
        if (!rst_sync_ff)
        begin
            rise_cnt_ff <= 2'h0;
            step_cnt_ff <= 10'h000;
        end
        else if (!stepping)
        begin
            rise_cnt_ff <= 2'h0;
            step_cnt_ff <= 10'h000;
        end
        else
        begin
            if (cmp_rise)
                rise_cnt_ff <= rise_cnt_ff + 2'h1;
            if (tick)
                step_cnt_ff <= step_cnt_ff + 10'h001;
        end
    end

    // position is not touched on start without reload, so it carries over
    always_ff @(posedge clk or negedge rst_sync_ff)
    begin
        if (!rst_sync_ff)
            pos_ff <= RELOAD_POS;
        else if (state_ff == tac_pkg::TAC_LOAD)
            pos_ff <= RELOAD_POS;
        else if (step_now)
            pos_ff <= sat_step(pos_ff, !level_comparator);
    end

    // strobe and direction travel together so the far side sees a matched pair
    always_ff @(posedge clk or negedge rst_sync_ff)
    begin
        if (!rst_sync_ff)
        begin
            step_pulse <= 1'b0;
            step_up    <= 1'b0;
        end
        else
        begin
            step_pulse <= step_now;
            step_up    <= !level_comparator;
        end
    end

    // the visible position lags the counter by one cycle, so it moves in the cycle after step_pulse
    always_ff @(posedge clk or negedge rst_sync_ff)
    begin
        if (!rst_sync_ff)
            position <= RELOAD_POS;
        else
            position <= pos_ff;
    end

    // busy follows the next state so it rises in the cycle after the start edge
    always_ff @(posedge clk or negedge rst_sync_ff)
    begin
        if (!rst_sync_ff)
        begin
            busy <= 1'b0;
            done <= 1'b0;
        end
        else
        begin
            busy <= will_be_busy;
            done <= stepping && stop_now;
        end
    end

    // the status word repeats busy, done and position for a consumer that wants one bus; reset clears its pos to 0, not RELOAD_POS
    always_ff @(posedge clk or negedge rst_sync_ff)
    begin
        if (!rst_sync_ff)
            status <= '0;
        else
            status <= '{busy: will_be_busy,
                        done: stepping && stop_now,
                        pos:  pos_ff};
    end
endmodule

// *** logic/tac_params.svh ***
// constants of the tracking converter step control
`ifndef TAC_PARAMS_SVH
`define TAC_PARAMS_SVH
`define TAC_POS_W        10
`define TAC_POS_MAX      10'h3FF
`define TAC_POS_MIN      10'h000
`define TAC_RELOAD_POS   10'h200
`define TAC_STOP_EDGES   2'h3
`define TAC_CLK_HZ       10000000
`define TAC_STEP_MAX_HZ  1000
`define TAC_STEP_DIV     (`TAC_CLK_HZ / `TAC_STEP_MAX_HZ)
`define TAC_MAX_STEPS    (512 + 5)
`endif

// *** logic/tac_pkg.sv ***
// types of the tracking converter step control
package tac_pkg;
    typedef enum logic [2:0] {
        TAC_IDLE = 3'h1,
        TAC_LOAD = 3'h2,
        TAC_STEP = 3'h4
    } tac_state_t;

    typedef struct packed {
        logic       busy;
        logic       done;
        logic [9:0] pos;
    } tac_status_t;
endpackage

// *** logic/tac_step_tick.sv ***
// stepping clock divider: one-cycle tick at most once per period
`timescale 1ns/1ps
`include "tac_params.svh"
module tac_step_tick #(
    parameter int DIV = `TAC_STEP_DIV
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic run,
    output logic      tick
);
    logic [31:0] cnt_ff;

    // the tick period never falls below DIV cycles, capping the rate
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_ff <= 32'h0;
            tick   <= 1'b0;
        end
        else if (!run)
        begin
            cnt_ff <= 32'h0;
            tick   <= 1'b0;
        end
        else if (cnt_ff == 32'(DIV - 1))
        begin
            cnt_ff <= 32'h0;
            tick   <= 1'b1;
        end
        else
        begin
            cnt_ff <= cnt_ff + 32'h1;
            tick   <= 1'b0;
        end
    end
endmodule

// *** tb/tac_cmp_model.sv ***
// comparator and divider model standing on the far side of the wiper
`timescale 1ns/1ps
module tac_cmp_model (
    input  wire logic       clk,
    input  wire logic [9:0] wiper,
    input  wire logic [9:0] vin,
    input  wire logic       step_pulse,
    output logic            above,
    output int              fast_count
);
    int gap = 0;
    int fast_cnt = 0;
    assign above = wiper > vin;
    assign fast_count = fast_cnt;
    // flags and counts a wiper that switches faster than four cycles apart
    always @(posedge clk)
    begin
        gap <= step_pulse ? 0 : gap + 1;
        if (step_pulse && gap < 3)
        begin
            fast_cnt <= fast_cnt + 1;
            $display("unexpected at %0t: fast step", $time);
        end
    end
endmodule

// *** tb/tac_step_control_props.sv ***
// port assertions of the tracking converter step control
`timescale 1ns/1ps
module tac_step_control_props (
    input wire logic                 clk,
    input wire logic                 nrst,
    input wire logic                 start,
    input wire logic                 auto_reload,
    input wire logic                 level_comparator,
    input wire logic                 step_pulse,
    input wire logic                 step_up,
    input wire logic [9:0]           position,
    input wire logic                 busy,
    input wire logic                 done,
    input wire tac_pkg::tac_status_t status
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    a_idle_no_step: assert property (step_pulse |-> $past(busy))
        else $error("step outside conversion");
    a_step_up_one: assert property (step_pulse && step_up && position != 10'h3FF
        |=> position == $past(position) + 10'h001) else $error("bad up step");
    a_step_down_one: assert property (step_pulse && !step_up && position != 10'h000
        |=> position == $past(position) - 10'h001) else $error("bad down step");
    a_step_dir_follow: assert property (step_pulse |-> step_up == !$past(level_comparator))
        else $error("step direction wrong");
    a_pos_saturate: assert property (step_pulse && position == (step_up ? 10'h3FF : 10'h000)
        |=> $stable(position)) else $error("position wrapped");
    a_done_marks_end: assert property (done == $fell(busy))
        else $error("done and busy disagree");
    a_done_one_cycle: assert property (done |=> !done)
        else $error("done too long");
    a_start_sets_busy: assert property ($rose(start) && !busy |=> busy)
        else $error("start ignored");
    a_reload_mid: assert property ($rose(busy) && auto_reload |-> ##[1:4] position == 10'h200)
        else $error("no reload");
    a_keep_position: assert property ($rose(busy) && !auto_reload |=> $stable(position)[*3])
        else $error("position reloaded");
endmodule
bind tac_step_control tac_step_control_props tac_step_control_props_i (.clk(clk), .nrst(nrst),
    .start(start), .auto_reload(auto_reload), .level_comparator(level_comparator),
    .step_pulse(step_pulse), .step_up(step_up), .position(position), .busy(busy),
    .done(done), .status(status));

// *** tb/tb.sv ***
// testbench of the tracking converter step control
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0, nrst = 1'b0, start = 1'b0, auto_reload = 1'b0;
    logic [9:0] vin = 10'h000, position;
    logic level_comparator, step_pulse, step_up, busy, done;
    tac_pkg::tac_status_t status;
    int fail_count = 0, checks = 0, cyc = 0;
    int fast_steps;
    always #50 clk = ~clk;
    // a short divider keeps the 517-step backstop run brief
    tac_step_control #(.STEP_DIV(4)) tac_step_control_i (.clk(clk), .nrst(nrst), .start(start),
        .auto_reload(auto_reload), .level_comparator(level_comparator), .step_pulse(step_pulse),
        .step_up(step_up), .position(position), .busy(busy), .done(done), .status(status));
    tac_cmp_model tac_cmp_model_i (.clk(clk), .wiper(position), .vin(vin),
        .step_pulse(step_pulse), .above(level_comparator), .fast_count(fast_steps));
    task check(input logic [9:0] seen, input logic [9:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 10000)
        begin
            fail_count++;
            wrap_up();
        end
    end
    // start stays high through the end to show that busy still drops
    task conv(input logic ar, input logic [9:0] v, input logic [9:0] e, input int n);
        int k, steps;
        steps = 0;
        auto_reload = ar;
        vin = v;
        repeat (4) @(negedge clk);
        start = 1'b1;
        for (k = 0; k < 3000 && done !== 1'b1; k++)
        begin
            @(negedge clk);
            steps += (step_pulse === 1'b1);
        end
        check({7'h00, status.done, status.busy, done}, 10'h005);
        repeat (3)
        begin
            @(negedge clk);
            steps += (step_pulse === 1'b1);
        end
        check(steps[9:0], n[9:0]);
        check(position, e);
        check(status.pos, e);
        check({9'h000, busy}, 10'h000);
        start = 1'b0;
        $display("conversion toward %h ended", v);
    endtask
    initial
    begin
        repeat (12) @(negedge clk);
        nrst = 1'b1;
        repeat (4) @(negedge clk);
        check(position, 10'h200);
        conv(1'b1, 10'h208, 10'h209, 13);
        conv(1'b0, 10'h1F4, 10'h1F5, 26);
        conv(1'b1, 10'h3FF, 10'h3FF, 517);
        conv(1'b0, 10'h3E8, 10'h3E9, 28);
        check(fast_steps[9:0], 10'h000);
        wrap_up();
    end
endmodule
